// [mrpc_pkg.sv]
// Purpose: shared constants and carriers for the macrocell preload chain
// Assumes: one clock, asynchronous active-low reset
// Notes: eight output macrocells, one registered bit each when so configured
package mrpc_pkg;

  // ==========================================================
  // sizes and reset values
  localparam int MRPC_CELLS = 8;
  localparam int MRPC_SIG_BITS = 64;
  localparam logic [MRPC_CELLS-1:0] MRPC_REG_RST = 8'h00;
  localparam logic [MRPC_SIG_BITS-1:0] MRPC_SIG_RST = 64'h0000_0000_0000_0000;
  localparam logic [MRPC_CELLS-1:0] MRPC_CFG_RST = 8'h00;

  // ==========================================================
  // power-up reset interval in microseconds and in clock cycles
  localparam int MRPC_CLK_MHZ = 100;
  localparam int MRPC_RESET_US = 45;
  localparam int MRPC_RESET_CYC = MRPC_RESET_US * MRPC_CLK_MHZ;
  localparam int MRPC_RCNT_W = 13;

  // ==========================================================
  // programming commands
  typedef enum logic [2:0] {
    MRPC_CMD_NONE = 3'b000,
    MRPC_CMD_ERASE = 3'b001,
    MRPC_CMD_PROG_CFG = 3'b010,
    MRPC_CMD_PROG_SIG = 3'b011,
    MRPC_CMD_SECURE = 3'b100,
    MRPC_CMD_VERIFY = 3'b101
  } mrpc_cmd_e;

  typedef enum logic [1:0] {
    MRPC_ST_PWRUP = 2'b00,
    MRPC_ST_NORMAL = 2'b01,
    MRPC_ST_PRELOAD = 2'b10
  } mrpc_state_e;

  // programming request carrier
  typedef struct packed {
    logic valid;
    mrpc_cmd_e cmd;
    logic [MRPC_SIG_BITS-1:0] data;
  } mrpc_req_s;

  // programming answer carrier
  typedef struct packed {
    logic done;
    logic refused;
    logic [MRPC_SIG_BITS-1:0] data;
  } mrpc_rsp_s;

endpackage

// [mrpc_cell.sv]
// Purpose: one macrocell register with preload chain bypass
// Assumes: chain input is the previous registered cell output or bypass
// Notes: a non-registered cell just passes the chain through
`timescale 1ns/10ps
module mrpc_cell
  import mrpc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic is_reg,
  input wire logic run_en,
  input wire logic shift_en,
  input wire logic func_d,
  input wire logic chain_in,
  output logic chain_out,
  output logic reg_q
);

  // ==========================================================
  // register: cleared at power-up, shifts or clocks normally
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_q <= 1'b0; // R1
    end else if (is_reg && shift_en) begin
      reg_q <= chain_in; // R6
    end else if (is_reg && run_en) begin
      reg_q <= func_d; // R12
    end
  end

  // bypass keeps unregistered cells out of the chain
  assign chain_out = is_reg ? reg_q : chain_in; // R5

endmodule

// [mrpc_prog.sv]
// Purpose: protection cell, signature word and bulk erase
// Assumes: one command per valid pulse, answer one cycle later
// Notes: signature never steers logic; it is only stored and read
`timescale 1ns/10ps
module mrpc_prog
  import mrpc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire mrpc_req_s req,
  output mrpc_rsp_s rsp,
  output logic [MRPC_CELLS-1:0] cfg_q,
  output logic secure_q
);

  logic [MRPC_SIG_BITS-1:0] sig_q;
  logic blocked;

  // array access locked once the protection cell is set
  assign blocked = secure_q && (req.cmd == MRPC_CMD_PROG_CFG
                   || req.cmd == MRPC_CMD_VERIFY || req.cmd == MRPC_CMD_SECURE); // R13

  // ==========================================================
  // stored cells; only erase clears protection, and with it all else
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= MRPC_CFG_RST;
      sig_q <= MRPC_SIG_RST;
      secure_q <= 1'b0;
    end else if (req.valid) begin
      case (req.cmd)
        MRPC_CMD_ERASE: begin
          cfg_q <= MRPC_CFG_RST; // R17
          sig_q <= MRPC_SIG_RST; // R17
          secure_q <= 1'b0; // R14
        end
        MRPC_CMD_PROG_CFG: begin
          if (!blocked) begin
            cfg_q <= req.data[MRPC_CELLS-1:0];
          end
        end
        MRPC_CMD_PROG_SIG: begin
          sig_q <= req.data; // R15
        end
        MRPC_CMD_SECURE: begin
          secure_q <= 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // answer: signature reads bypass the lock, array reads do not
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp <= '0;
    end else begin
      rsp.done <= req.valid;
      rsp.refused <= req.valid && blocked; // R13
      if (req.valid && req.cmd == MRPC_CMD_PROG_SIG) begin
        rsp.data <= sig_q; // R16
      end else if (req.valid && req.cmd == MRPC_CMD_VERIFY && !blocked) begin
        rsp.data <= {{(MRPC_SIG_BITS-MRPC_CELLS){1'b0}}, cfg_q};
      end else if (req.valid) begin
        rsp.data <= sig_q; // R16
      end
    end
  end

endmodule

// [mrpc_top.sv]
// Purpose: macrocell registers with serial preload and readback
// Assumes: preload_select is a logic level already decoded from the
//   elevated pin voltage; clock edges arrive as functional clock enables
// Notes: serial_preload_out is open drain, driven only while low
`timescale 1ns/10ps
// Notes on behaviour
// R1 - power-up clears every macrocell register
// R2 - common clock and output enable when registered
// R3 - tester waits out power-up reset interval
// R4 - elevated select level enters preload mode
// R5 - one chain bit per registered cell
// R6 - one shift per rising clock edge
// R7 - enters lowest cell, first bit ends highest
// R8 - old contents shift out serially
// R9 - low is zero, high is one
// R10 - register value inverted on output pin
// R11 - readback ignores output enable state
// R12 - normal clocking resumes from loaded state
// R13 - protection blocks array programming and verify
// R14 - protection cleared only by bulk erase
// R15 - 64-bit signature, no logic effect
// R16 - signature readable despite protection
// R17 - bulk erase clears everything
// R18 - tester drops select before functional clocks
module mrpc_top
  import mrpc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic preload_select,
  input wire logic preload_shift_clock,
  input wire logic serial_preload_in,
  input wire logic out_enable_n,
  input wire logic [MRPC_CELLS-1:0] next_state,
  input wire mrpc_req_s prog_req,
  output mrpc_rsp_s prog_rsp,
  output logic serial_preload_out_o,
  output logic serial_preload_out_oe,
  output logic [MRPC_CELLS-1:0] cell_pin_o,
  output logic [MRPC_CELLS-1:0] cell_pin_oe,
  output logic reset_done,
  output logic preload_active
);

  mrpc_state_e state_q;
  logic [MRPC_RCNT_W-1:0] rcnt_q;
  logic clk_prev_q;
  logic clk_rise;
  logic shift_en;
  logic run_en;
  logic [MRPC_CELLS:0] chain;
  logic [MRPC_CELLS-1:0] reg_q;
  logic [MRPC_CELLS-1:0] cfg_q;
  logic secure_q;
  logic sdo_q;

  // ==========================================================
  // edge detect on the shared clock pin, which is also the shift clock
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= preload_shift_clock;
    end
  end

  assign clk_rise = preload_shift_clock && !clk_prev_q;

  // ==========================================================
  // power-up interval counter; edges during it are dropped
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rcnt_q <= '0;
    end else if (state_q == MRPC_ST_PWRUP) begin
      rcnt_q <= rcnt_q + 1'b1;
    end
  end

  // ==========================================================
  // mode machine
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= MRPC_ST_PWRUP;
    end else begin
      case (state_q)
        MRPC_ST_PWRUP: begin
          // tester must not preload earlier; such edges are ignored
          if (rcnt_q == MRPC_RCNT_W'(MRPC_RESET_CYC - 1)) begin
            state_q <= MRPC_ST_NORMAL; // R3
          end
        end
        MRPC_ST_NORMAL: begin
          if (preload_select) begin
            state_q <= MRPC_ST_PRELOAD; // R4
          end
        end
        MRPC_ST_PRELOAD: begin
          if (!preload_select) begin
            state_q <= MRPC_ST_NORMAL; // R18
          end
        end
        default: begin
          state_q <= MRPC_ST_PWRUP;
        end
      endcase
    end
  end

  assign shift_en = (state_q == MRPC_ST_PRELOAD) && preload_select && clk_rise; // R6
  assign run_en = (state_q == MRPC_ST_NORMAL) && !preload_select && clk_rise; // R2
  assign reset_done = (state_q != MRPC_ST_PWRUP);
  assign preload_active = (state_q == MRPC_ST_PRELOAD);

  // ==========================================================
  // chain enters at cell 0 (lowest pin) and moves up
  assign chain[0] = serial_preload_in; // R7

  genvar gi;
  generate
    for (gi = 0; gi < MRPC_CELLS; gi++) begin : g_cell
      mrpc_cell u_cell (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .is_reg(cfg_q[gi]),
        .run_en(run_en),
        .shift_en(shift_en),
        .func_d(next_state[gi]),
        .chain_in(chain[gi]),
        .chain_out(chain[gi+1]),
        .reg_q(reg_q[gi])
      );
    end
  endgenerate

  // ==========================================================
  // serial readback, independent of the output enable pin
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sdo_q <= 1'b1;
    end else begin
      sdo_q <= chain[MRPC_CELLS]; // R8 R11 R9
    end
  end

  // open drain: pull low for zero, release for one
  assign serial_preload_out_o = 1'b0;
  assign serial_preload_out_oe = preload_active && !sdo_q; // R9

  // ==========================================================
  // normal pins: active-low register view, common enable
  assign cell_pin_o = ~reg_q; // R10
  assign cell_pin_oe = (!out_enable_n && !preload_active) ? cfg_q : '0; // R2

  // ==========================================================
  // programming side
  mrpc_prog u_prog (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .req(prog_req),
    .rsp(prog_rsp),
    .cfg_q(cfg_q),
    .secure_q(secure_q)
  );

  // ==========================================================
  // checks
  property p_pwrup_clear;
    @(posedge ref_clk) disable iff (!arst_n)
    (state_q == MRPC_ST_PWRUP) |-> (reg_q == MRPC_REG_RST);
  endproperty
  a_pwrup_clear: assert property (p_pwrup_clear) else $error("register set in power-up"); // R1

  property p_no_early_preload;
    @(posedge ref_clk) disable iff (!arst_n)
    (state_q == MRPC_ST_PWRUP) |=> (state_q != MRPC_ST_PRELOAD);
  endproperty
  a_no_early_preload: assert property (p_no_early_preload) else $error("early preload"); // R3

  property p_enter;
    @(posedge ref_clk) disable iff (!arst_n)
    (state_q == MRPC_ST_NORMAL && preload_select) |=> preload_active;
  endproperty
  a_enter: assert property (p_enter) else $error("preload not entered"); // R4

  property p_shift_in;
    @(posedge ref_clk) disable iff (!arst_n)
    (shift_en && cfg_q[0]) |=> (reg_q[0] == $past(serial_preload_in));
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("lowest cell missed bit"); // R7

  property p_shift_up;
    @(posedge ref_clk) disable iff (!arst_n)
    (shift_en && cfg_q[1] && cfg_q[0]) |=> (reg_q[1] == $past(reg_q[0]));
  endproperty
  a_shift_up: assert property (p_shift_up) else $error("chain did not move up"); // R6

  property p_readout;
    @(posedge ref_clk) disable iff (!arst_n)
    // the top cell may move on a functional edge, so compare its old value
    cfg_q[MRPC_CELLS-1] |=> (sdo_q == $past(reg_q[MRPC_CELLS-1]));
  endproperty
  a_readout: assert property (p_readout) else $error("readback mismatch"); // R8

  property p_bypass;
    @(posedge ref_clk) disable iff (!arst_n)
    (shift_en && !cfg_q[2]) |=> (reg_q[2] == $past(reg_q[2]));
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypassed cell changed"); // R5

  property p_invert;
    @(posedge ref_clk) disable iff (!arst_n)
    cell_pin_o[3] != reg_q[3];
  endproperty
  a_invert: assert property (p_invert) else $error("pin not inverted"); // R10

  property p_resume;
    @(posedge ref_clk) disable iff (!arst_n)
    (run_en && cfg_q[0]) |=> (reg_q[0] == $past(next_state[0]));
  endproperty
  a_resume: assert property (p_resume) else $error("functional clock lost"); // R12

  property p_lock;
    @(posedge ref_clk) disable iff (!arst_n)
    (secure_q && prog_req.valid && prog_req.cmd == MRPC_CMD_PROG_CFG)
      |=> (prog_rsp.refused && $stable(cfg_q));
  endproperty
  a_lock: assert property (p_lock) else $error("locked array accessed"); // R13

  property p_erase;
    @(posedge ref_clk) disable iff (!arst_n)
    (prog_req.valid && prog_req.cmd == MRPC_CMD_ERASE) |=> (!secure_q && cfg_q == MRPC_CFG_RST);
  endproperty
  a_erase: assert property (p_erase) else $error("erase incomplete"); // R17

  property p_secure_hold;
    @(posedge ref_clk) disable iff (!arst_n)
    (secure_q && !(prog_req.valid && prog_req.cmd == MRPC_CMD_ERASE)) |=> secure_q;
  endproperty
  a_secure_hold: assert property (p_secure_hold) else $error("protection lost"); // R14

  property p_secure_set;
    @(posedge ref_clk) disable iff (!arst_n)
    (prog_req.valid && prog_req.cmd == MRPC_CMD_SECURE) |=> secure_q;
  endproperty
  a_secure_set: assert property (p_secure_set) else $error("protection not set"); // R13

  property p_verify_lock;
    @(posedge ref_clk) disable iff (!arst_n)
    (secure_q && prog_req.valid && prog_req.cmd == MRPC_CMD_VERIFY) |=> prog_rsp.refused;
  endproperty
  a_verify_lock: assert property (p_verify_lock) else $error("locked verify answered"); // R13

  property p_sig_open;
    @(posedge ref_clk) disable iff (!arst_n)
    (prog_req.valid && prog_req.cmd == MRPC_CMD_PROG_SIG) |=> !prog_rsp.refused;
  endproperty
  a_sig_open: assert property (p_sig_open) else $error("signature access refused"); // R16

  property p_answer;
    @(posedge ref_clk) disable iff (!arst_n)
    prog_req.valid |=> prog_rsp.done;
  endproperty
  a_answer: assert property (p_answer) else $error("command not answered"); // R17

  property p_pwrup_idle;
    @(posedge ref_clk) disable iff (!arst_n)
    (state_q == MRPC_ST_PWRUP) |-> !(shift_en || run_en);
  endproperty
  a_pwrup_idle: assert property (p_pwrup_idle) else $error("edge taken in power-up"); // R1

  property p_exit;
    @(posedge ref_clk) disable iff (!arst_n)
    (preload_active && !preload_select) |=> !preload_active;
  endproperty
  a_exit: assert property (p_exit) else $error("preload not left"); // R18

  property p_hold;
    @(posedge ref_clk) disable iff (!arst_n)
    (!shift_en && !run_en) |=> $stable(reg_q);
  endproperty
  a_hold: assert property (p_hold) else $error("register moved without an edge"); // R12

  property p_chain_empty;
    @(posedge ref_clk) disable iff (!arst_n)
    (cfg_q == '0) |=> (sdo_q == $past(serial_preload_in));
  endproperty
  a_chain_empty: assert property (p_chain_empty) else $error("empty chain not bypassed"); // R5

  // open-drain level must follow the top cell whatever the pin enables are
  property p_sdo_level;
    @(posedge ref_clk) disable iff (!arst_n)
    (preload_active && cfg_q[MRPC_CELLS-1]) ##1 preload_active
      |-> (serial_preload_out_oe != $past(reg_q[MRPC_CELLS-1]));
  endproperty
  a_sdo_level: assert property (p_sdo_level) else $error("serial out level wrong"); // R9

  property p_oe_off;
    @(posedge ref_clk) disable iff (!arst_n)
    out_enable_n |-> (cell_pin_oe == '0);
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("pin driven while disabled"); // R2

  c_preload: cover property (@(posedge ref_clk) disable iff (!arst_n) shift_en);
  c_resume: cover property (@(posedge ref_clk) disable iff (!arst_n)
    preload_active ##1 !preload_active ##[1:20] run_en);
  c_secure_refuse: cover property (@(posedge ref_clk) disable iff (!arst_n) prog_rsp.refused);
  c_bypass_shift: cover property (@(posedge ref_clk) disable iff (!arst_n)
    shift_en && cfg_q != '1 && cfg_q != '0);

endmodule

// [mrpc_tester.sv]
// Purpose: test equipment model driving the preload pins
// Assumes: the elevated select voltage is modelled as a logic level
// Notes: shift clock idles low outside frames; all moves 1 ns after an edge
`timescale 1ns/10ps
module mrpc_tester
  import mrpc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sdo_wire,
  output logic preload_select,
  output logic preload_shift_clock,
  output logic serial_preload_in
);
  // ==========================================================
  // idle levels from time zero
  initial begin
    preload_select = 1'h0;
    preload_shift_clock = 1'h0;
    serial_preload_in = 1'h0;
  end

  // one clock edge, then move off it to avoid races
  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask

  // select level change, two edges for the mode to settle
  task automatic set_select(input logic lvl);
    preload_select = lvl;
    step();
    step();
  endtask

  // one shift pulse; the low phase spans edges so each rise is seen
  task automatic pulse(input logic din, output logic dout);
    dout = sdo_wire;
    serial_preload_in = din;
    step();
    preload_shift_clock = 1'h1;
    step();
    preload_shift_clock = 1'h0;
    step();
    step();
  endtask
endmodule

// [mrpc_top_tb.sv]
// Purpose: self-checking bench for the macrocell preload chain
// Assumes: the full power-up interval is run once, it is short enough
// Notes: serial output is open drain, pulled high here
`timescale 1ns/10ps
module mrpc_top_tb
  import mrpc_pkg::*;
;
  logic ref_clk;
  logic arst_n;
  logic out_enable_n;
  logic [MRPC_CELLS-1:0] next_state;
  logic [MRPC_CELLS-1:0] cell_pin_o;
  logic [MRPC_CELLS-1:0] cell_pin_oe;
  mrpc_req_s prog_req;
  mrpc_rsp_s prog_rsp;
  mrpc_rsp_s r;
  logic sel, sclk, sdi, sdo_o, sdo_oe, sdo_wire, reset_done, preload_active;
  logic [7:0] got;
  logic [7:0] pins;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;

  // pull-up stands in for the external resistor
  assign sdo_wire = sdo_oe ? sdo_o : 1'h1;

  mrpc_top dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .preload_select(sel),
    .preload_shift_clock(sclk), .serial_preload_in(sdi),
    .out_enable_n(out_enable_n), .next_state(next_state), .prog_req(prog_req),
    .prog_rsp(prog_rsp), .serial_preload_out_o(sdo_o), .serial_preload_out_oe(sdo_oe),
    .cell_pin_o(cell_pin_o), .cell_pin_oe(cell_pin_oe), .reset_done(reset_done),
    .preload_active(preload_active)
  );

  mrpc_tester tester (
    .ref_clk(ref_clk), .sdo_wire(sdo_wire), .preload_select(sel),
    .preload_shift_clock(sclk), .serial_preload_in(sdi)
  );

  // ==========================================================
  // clock and hang guard
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ceiling well above the roughly 4600 cycles the run needs
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end

  task automatic close_out();
    if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ==========================================================
  // shared drivers
  task automatic prog(input mrpc_cmd_e cmd, input logic [63:0] d);
    prog_req.cmd = cmd;
    prog_req.data = d;
    prog_req.valid = 1'h1;
    tester.step();
    prog_req.valid = 1'h0;
    for (int i = 0; i < 4 && prog_rsp.done !== 1'h1; i++) tester.step();
    r = prog_rsp;
    check(r.done, 1'h1);
    // let an edge pass so valid never falls and rises in one time step
    tester.step();
  endtask

  // msb first, so the first bit ends in the highest cell
  task automatic shift_word(input logic [7:0] v, input int n);
    logic b;
    got = 8'h00;
    for (int i = n - 1; i >= 0; i--) begin
      tester.pulse(v[i], b);
      got = {got[6:0], b};
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    check(cell_pin_o, 8'hFF);
    check(cell_pin_oe, 8'h00);
    // tester holds off preload until the interval is over
    for (int i = 0; i < 5000 && reset_done !== 1'h1; i++) tester.step();
    check(reset_done, 1'h1);
  endtask

  task automatic t_chain();
    prog(MRPC_CMD_ERASE, 64'h0000_0000_0000_0000);
    prog(MRPC_CMD_PROG_CFG, 64'h0000_0000_0000_00FF);
    prog(MRPC_CMD_VERIFY, 64'h0000_0000_0000_0000);
    check(r.data, 64'h0000_0000_0000_00FF);
    out_enable_n = 1'h1;
    tester.set_select(1'h1);
    check(preload_active, 1'h1);
    shift_word(8'hA5, 8);
    check(got, 8'h00);
    check(cell_pin_o, 8'h5A);
    shift_word(8'h3C, 8);
    check(got, 8'hA5);
    tester.set_select(1'h0);
    check(cell_pin_o, 8'hC3);
    out_enable_n = 1'h0;
    tester.step();
    check(cell_pin_oe, 8'hFF);
    next_state = 8'h96;
    shift_word(8'h00, 1);
    check(cell_pin_o, 8'h69);
  endtask

  // only cells 1 and 3 registered: a two-bit chain
  task automatic t_bypass();
    prog(MRPC_CMD_ERASE, 64'h0000_0000_0000_0000);
    prog(MRPC_CMD_PROG_CFG, 64'h0000_0000_0000_000A);
    next_state = 8'hFF;
    shift_word(8'h00, 1);
    pins = cell_pin_o;
    check(pins, 8'h61);
    tester.set_select(1'h1);
    shift_word(8'h01, 2);
    check(got, 8'h03);
    check(cell_pin_o, 8'h69);
    shift_word(8'h00, 2);
    check(got, 8'h01);
    tester.set_select(1'h0);
  endtask

  task automatic t_protect();
    prog(MRPC_CMD_ERASE, 64'h0000_0000_0000_0000);
    prog(MRPC_CMD_PROG_SIG, 64'hC0DE_1234_5678_9ABC);
    prog(MRPC_CMD_SECURE, 64'h0000_0000_0000_0000);
    check(r.refused, 1'h0);
    prog(MRPC_CMD_PROG_CFG, 64'h0000_0000_0000_00FF);
    check(r.refused, 1'h1);
    prog(MRPC_CMD_VERIFY, 64'h0000_0000_0000_0000);
    check(r.refused, 1'h1);
    prog(MRPC_CMD_SECURE, 64'h0000_0000_0000_0000);
    check(r.refused, 1'h1);
    prog(MRPC_CMD_PROG_SIG, 64'h0000_0000_0000_0001);
    check(r.refused, 1'h0);
    check(r.data, 64'hC0DE_1234_5678_9ABC);
    prog(MRPC_CMD_ERASE, 64'h0000_0000_0000_0000);
    prog(MRPC_CMD_VERIFY, 64'h0000_0000_0000_0000);
    check(r.refused, 1'h0);
    check(r.data, 64'h0000_0000_0000_0000);
    prog(MRPC_CMD_PROG_SIG, 64'h0000_0000_0000_0002);
    check(r.data, 64'h0000_0000_0000_0000);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    arst_n = 1'h0;
    out_enable_n = 1'h1;
    next_state = 8'h00;
    prog_req = '0;
    repeat (5) @(posedge ref_clk);
    #1;
    arst_n = 1'h1;
    t_reset();
    t_chain();
    t_bypass();
    t_protect();
    close_out();
  end
endmodule
